// ===== rtl/pfs_pkg.sv
// Package for the port pin function select block: offsets, fields, resets, modes
package pfs_pkg;

	// Register byte offsets on APB
	localparam logic [11:0] OFS_FUNC_ASSIGN = 12'h00A;
	localparam logic [11:0] OFS_PULLUP      = 12'h00C;
	localparam logic [11:0] OFS_DRIVE       = 12'h00D;
	localparam logic [11:0] OFS_MODE        = 12'h00B;

	// Function-assign field positions
	localparam int FA_AUX_RST  = 7;
	localparam int FA_SYNTH    = 6;
	localparam int FA_QUEUE    = 5;
	localparam int FA_ECLK_DIS = 4;
	localparam int FA_LOW_BYTE_STROBE    = 3;
	localparam int FA_RW       = 2;
	localparam logic [7:0] FA_IMPL_MASK = 8'hFC;

	// Mode-register field position
	localparam int MODE_INTERNAL_VISIBILITY = 3;

	// Per-mode reset values of the function-assign register, then pullup and drive resets
	localparam logic [7:0] FA_RST_SPECIAL = 8'h2C;
	localparam logic [7:0] FA_RST_PERIPH  = 8'h50;
	localparam logic [7:0] FA_RST_NSC     = 8'h10;
	localparam logic [7:0] FA_RST_NEXP    = 8'h00;
	localparam logic [7:0] PULLUP_RST     = 8'h00;
	localparam logic [7:0] DRIVE_RST      = 8'h00;

	// Operating modes as captured from the mode straps
	typedef enum logic [2:0] {
		MODE_SPECIAL_SC   = 3'h0,
		MODE_SPECIAL_EXPN = 3'h1,
		MODE_PERIPHERAL   = 3'h2,
		MODE_SPECIAL_EXPW = 3'h3,
		MODE_NORMAL_SC    = 3'h4,
		MODE_NORMAL_EXPN  = 3'h5,
		MODE_NORMAL_EXPW  = 3'h7
	} pfs_mode_e;

	// Per-pin drive of port E bits 7..2: output value, enable and direction source
	typedef struct packed {
		logic [7:2] alt_sel;
		logic [7:2] out_val;
		logic [7:2] out_drive;
	} pfs_porte_s;

endpackage : pfs_pkg

// ===== rtl/pfs_port_pin_function_select.sv
// Port pin function select: bus-control pin mux, pullups and drive strength
//
// Design decisions made here: the register offsets and register access over APB.
`timescale 1ns/1ps
`default_nettype none

module pfs_port_pin_function_select (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic [2:0]  mode_pins,
	input  wire logic        addr_bus_a,
	input  wire logic        addr_bus_b,
	input  wire logic        data_bus_c,
	input  wire logic        data_bus_d,
	input  wire logic [7:0]  port_e_direction,
	input  wire logic [7:0]  port_e_data,
	input  wire logic [7:0]  port_e_pin_in,
	input  wire logic [7:0]  dir_a,
	input  wire logic [7:0]  dir_b,
	input  wire logic [7:0]  dir_c,
	input  wire logic [7:0]  dir_d,
	input  wire logic [7:0]  dir_f,
	input  wire logic [7:0]  dir_g,
	input  wire logic [7:0]  dir_h,
	input  wire logic        synth_test_sig,
	input  wire logic [1:0]  queue_state,
	input  wire logic        bus_eclk,
	input  wire logic        bus_low_byte_strobe,
	input  wire logic        bus_rw,
	output logic      [7:0]  port_e_out,
	output logic      [7:0]  port_e_oe_n,
	output logic             aux_reset_req,
	output logic             eclk_in,
	output logic      [7:0]  pullup_a,
	output logic      [7:0]  pullup_b,
	output logic      [7:0]  pullup_c,
	output logic      [7:0]  pullup_d,
	output logic      [7:0]  pullup_e,
	output logic      [7:0]  pullup_f,
	output logic      [7:0]  pullup_g,
	output logic      [7:0]  pullup_h,
	output logic      [7:0]  weak_drive_port
);

	// ==============================================
	// Mode capture and pin synchronisers
	// Straps and pins pass two flip-flops before any logic reads them
	logic [2:0] mode_s1_ff;
	logic [2:0] mode_s2_ff;
	logic       mode_done_ff;
	logic [2:0] mode_ff;
	logic [7:0] pin_s1_ff;
	logic [7:0] pin_s2_ff;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode_s1_ff <= 3'h0;
			mode_s2_ff <= 3'h0;
			pin_s1_ff  <= 8'h00;
			pin_s2_ff  <= 8'h00;
		end else begin
			mode_s1_ff <= mode_pins;
			mode_s2_ff <= mode_s1_ff;
			pin_s1_ff  <= port_e_pin_in;
			pin_s2_ff  <= pin_s1_ff;
		end
	end

	// Straps are latched once, three edges after reset release
	logic [1:0] cap_cnt_ff;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cap_cnt_ff   <= 2'h0;
			mode_done_ff <= 1'b0;
			mode_ff      <= pfs_pkg::MODE_NORMAL_EXPN;
		end else if (!mode_done_ff) begin
			cap_cnt_ff <= cap_cnt_ff + 2'h1;
			if (cap_cnt_ff == 2'h2) begin
				mode_done_ff <= 1'b1;
				mode_ff      <= mode_s2_ff;
			end
		end
	end

	// Mode classes that every permission and mux decision uses
	logic is_normal;
	logic is_single;
	logic is_periph;
	logic is_nexpn;
	logic is_nexp;
	assign is_normal = mode_ff[2];
	assign is_single = (mode_ff == pfs_pkg::MODE_SPECIAL_SC) || (mode_ff == pfs_pkg::MODE_NORMAL_SC);
	assign is_periph = (mode_ff == pfs_pkg::MODE_PERIPHERAL);
	assign is_nexpn  = (mode_ff == pfs_pkg::MODE_NORMAL_EXPN);
	assign is_nexp   = is_nexpn || (mode_ff == pfs_pkg::MODE_NORMAL_EXPW);

	// ==============================================
	// APB decode
	logic wr_en;
	logic rd_hit;
	logic sel_fa;
	logic sel_pu;
	logic sel_dr;
	logic sel_md;
	logic lane_fa;
	logic lane_pu;
	logic lane_dr;
	logic lane_md;

	// Zero wait states: each access completes in its first access cycle
	assign pready  = 1'b1;
	assign wr_en   = psel && penable && pwrite;
	assign sel_fa  = (paddr[11:2] == pfs_pkg::OFS_FUNC_ASSIGN[11:2]);
	assign sel_md  = (paddr[11:2] == pfs_pkg::OFS_MODE[11:2]);
	// Pullup and drive words vanish in peripheral mode
	assign sel_pu  = (paddr[11:2] == pfs_pkg::OFS_PULLUP[11:2]) && !is_periph;
	assign sel_dr  = (paddr[11:2] == pfs_pkg::OFS_DRIVE[11:2]) && !is_periph;
	// Bytes are packed little-endian within the word: lane = offset low bits
	assign lane_fa = pstrb[pfs_pkg::OFS_FUNC_ASSIGN[1:0]];
	assign lane_md = pstrb[pfs_pkg::OFS_MODE[1:0]];
	assign lane_pu = pstrb[pfs_pkg::OFS_PULLUP[1:0]];
	assign lane_dr = pstrb[pfs_pkg::OFS_DRIVE[1:0]];
	// Function-assign byte is dropped in peripheral mode; the mode byte keeps its word mapped
	assign rd_hit  = (sel_fa && !is_periph) || sel_pu || sel_dr || sel_md;
	assign pslverr = psel && penable && !rd_hit;

	logic [7:0] wb_fa;
	logic [7:0] wb_md;
	logic [7:0] wb_pu;
	logic [7:0] wb_dr;
	assign wb_fa = pwdata[8*pfs_pkg::OFS_FUNC_ASSIGN[1:0] +: 8];
	assign wb_md = pwdata[8*pfs_pkg::OFS_MODE[1:0] +: 8];
	assign wb_pu = pwdata[8*pfs_pkg::OFS_PULLUP[1:0] +: 8];
	assign wb_dr = pwdata[8*pfs_pkg::OFS_DRIVE[1:0] +: 8];

	logic wr_fa;
	logic wr_md;
	// Any write of the function byte lane counts as the first write
	assign wr_fa = wr_en && sel_fa && !is_periph && lane_fa;
	assign wr_md = wr_en && sel_md && lane_md;

	// ==============================================
	// Function-assign register with per-bit write permissions
	logic [7:0] fa_ff;
	logic       first_wr_ff;
	logic       fa_init_ff;

	// Set-only lock flag; only a chip reset clears it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			first_wr_ff <= 1'b0;
		end else if (wr_fa) begin
			first_wr_ff <= 1'b1;
		end
	end

	// Reset value is loaded once the straps are known
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fa_ff      <= pfs_pkg::FA_RST_NEXP;
			fa_init_ff <= 1'b0;
		end else if (!fa_init_ff) begin
			if (mode_done_ff) begin
				fa_init_ff <= 1'b1;
				case (mode_s2_ff)
					pfs_pkg::MODE_SPECIAL_SC,
					pfs_pkg::MODE_SPECIAL_EXPN,
					pfs_pkg::MODE_SPECIAL_EXPW: fa_ff <= pfs_pkg::FA_RST_SPECIAL;
					pfs_pkg::MODE_PERIPHERAL:   fa_ff <= pfs_pkg::FA_RST_PERIPH;
					pfs_pkg::MODE_NORMAL_SC:    fa_ff <= pfs_pkg::FA_RST_NSC;
					default:                    fa_ff <= pfs_pkg::FA_RST_NEXP;
				endcase
			end
		end else if (wr_fa) begin
			fa_ff[pfs_pkg::FA_AUX_RST] <= wb_fa[pfs_pkg::FA_AUX_RST];
			if (is_normal) begin
				if (!first_wr_ff) begin
					fa_ff[pfs_pkg::FA_QUEUE] <= wb_fa[pfs_pkg::FA_QUEUE];
					fa_ff[pfs_pkg::FA_LOW_BYTE_STROBE] <= wb_fa[pfs_pkg::FA_LOW_BYTE_STROBE];
					fa_ff[pfs_pkg::FA_RW]    <= wb_fa[pfs_pkg::FA_RW];
				end
				fa_ff[pfs_pkg::FA_ECLK_DIS] <= wb_fa[pfs_pkg::FA_ECLK_DIS];
				// Synth test bit never written here
			end else if (first_wr_ff) begin
				// Special modes take only the aux reset bit on the first write and never take the clock disable
				fa_ff[pfs_pkg::FA_SYNTH] <= wb_fa[pfs_pkg::FA_SYNTH];
				fa_ff[pfs_pkg::FA_QUEUE] <= wb_fa[pfs_pkg::FA_QUEUE];
				fa_ff[pfs_pkg::FA_LOW_BYTE_STROBE] <= wb_fa[pfs_pkg::FA_LOW_BYTE_STROBE];
				fa_ff[pfs_pkg::FA_RW]    <= wb_fa[pfs_pkg::FA_RW];
			end
		end
	end

	// Visibility bit of the neighbouring mode byte, so one 16-bit write sets both
	logic internal_visibility_ff;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			internal_visibility_ff <= 1'b0;
		end else if (wr_md) begin
			internal_visibility_ff <= wb_md[pfs_pkg::MODE_INTERNAL_VISIBILITY];
		end
	end

	// ==============================================
	// Pullup and drive registers
	logic [7:0] pu_ff;
	logic [7:0] dr_ff;
	// Pullup enables are writable whenever their word is mapped
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pu_ff <= pfs_pkg::PULLUP_RST;
		end else if (wr_en && sel_pu && lane_pu) begin
			pu_ff <= wb_pu;
		end
	end

	// Special-mode drive writes are dropped without an error response
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dr_ff <= pfs_pkg::DRIVE_RST;
		end else if (wr_en && sel_dr && lane_dr && is_normal) begin
			dr_ff <= wb_dr;
		end
	end

	// Read mux
	logic [31:0] nxt_rdata;
	always_comb begin
		nxt_rdata = 32'h0000_0000;
		if (sel_fa && !is_periph) begin
			nxt_rdata[8*pfs_pkg::OFS_FUNC_ASSIGN[1:0] +: 8] = fa_ff & pfs_pkg::FA_IMPL_MASK;
		end
		if (sel_md) begin
			nxt_rdata[8*pfs_pkg::OFS_MODE[1:0] + pfs_pkg::MODE_INTERNAL_VISIBILITY] = internal_visibility_ff;
		end
		if (sel_pu) begin
			nxt_rdata[8*pfs_pkg::OFS_PULLUP[1:0] +: 8] = pu_ff;
		end
		if (sel_dr) begin
			nxt_rdata[8*pfs_pkg::OFS_DRIVE[1:0] +: 8] = dr_ff;
		end
	end

	// Read data is captured in the setup cycle and held until the next read
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else if (psel && !penable && !pwrite) begin
			prdata <= nxt_rdata;
		end
	end

	// ==============================================
	// Port E pin mux
	pfs_pkg::pfs_porte_s pe;
	logic eclk_on;
	always_comb begin
		pe = '0;
		eclk_on = !fa_ff[pfs_pkg::FA_ECLK_DIS] && (!is_single || internal_visibility_ff);
		// Bit 7 stays an input while used as reset
		pe.alt_sel[7] = fa_ff[pfs_pkg::FA_AUX_RST];
		// Queue status outranks the synth test output on bit 6
		if (fa_ff[pfs_pkg::FA_QUEUE] && !is_single) begin
			pe.alt_sel[6] = 1'b1;
			pe.alt_sel[5] = 1'b1;
			pe.out_drive[6] = 1'b1;
			pe.out_drive[5] = 1'b1;
			pe.out_val[6] = queue_state[1];
			pe.out_val[5] = queue_state[0];
		end else if (fa_ff[pfs_pkg::FA_SYNTH] && !is_single && !is_nexp) begin
			pe.alt_sel[6] = 1'b1;
			pe.out_drive[6] = 1'b1;
			pe.out_val[6] = synth_test_sig;
		end
		if (!fa_ff[pfs_pkg::FA_ECLK_DIS]) begin
			// Peripheral mode takes the bus clock in, so the pin is not driven there
			pe.alt_sel[4] = 1'b1;
			pe.out_drive[4] = !is_periph && eclk_on;
			pe.out_val[4] = bus_eclk;
		end
		if (fa_ff[pfs_pkg::FA_LOW_BYTE_STROBE] && !is_single && !is_nexpn) begin
			pe.alt_sel[3] = 1'b1;
			pe.out_drive[3] = 1'b1;
			pe.out_val[3] = bus_low_byte_strobe;
		end
		if (fa_ff[pfs_pkg::FA_RW] && !is_single) begin
			pe.alt_sel[2] = 1'b1;
			pe.out_drive[2] = 1'b1;
			pe.out_val[2] = bus_rw;
		end
	end

	// Output registers; unknown mode during reset defaults to bit 3 high driven
	logic [7:0] nxt_out;
	logic [7:0] nxt_oe_n;
	always_comb begin
		nxt_out  = port_e_data;
		nxt_oe_n = ~port_e_direction;
		// Bits 1:0 are interrupt inputs and never driven
		nxt_oe_n[1:0] = 2'b11;
		for (int i = 2; i < 8; i++) begin
			if (pe.alt_sel[i]) begin
				nxt_out[i]  = pe.out_val[i];
				nxt_oe_n[i] = !pe.out_drive[i];
			end
		end
		if (!fa_init_ff && is_nexpn) begin
			nxt_out[3]  = 1'b1;
			nxt_oe_n[3] = 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			port_e_out  <= 8'h08;
			port_e_oe_n <= 8'hF7;
		end else begin
			port_e_out  <= nxt_out;
			port_e_oe_n <= nxt_oe_n;
		end
	end

	// Aux reset and clock input read only the synchronised pin levels
	assign aux_reset_req = fa_ff[pfs_pkg::FA_AUX_RST] && pin_s2_ff[7];
	assign eclk_in = is_periph && !fa_ff[pfs_pkg::FA_ECLK_DIS] && pin_s2_ff[4];

	// ==============================================
	// Pullups and drive strength
	logic [7:0] pe_in_mask;
	// Port E pullups follow the registered direction of pins 3, 2 and 0
	assign pe_in_mask = port_e_oe_n & 8'h0D;
	assign pullup_a = (pu_ff[0] && !addr_bus_a) ? ~dir_a : 8'h00;
	assign pullup_b = (pu_ff[1] && !addr_bus_b) ? ~dir_b : 8'h00;
	assign pullup_c = (pu_ff[2] && !data_bus_c) ? ~dir_c : 8'h00;
	assign pullup_d = (pu_ff[3] && !data_bus_d) ? ~dir_d : 8'h00;
	assign pullup_e = pu_ff[4] ? pe_in_mask : 8'h00;
	assign pullup_f = pu_ff[5] ? ~dir_f : 8'h00;
	assign pullup_g = pu_ff[6] ? ~dir_g : 8'h00;
	assign pullup_h = pu_ff[7] ? ~dir_h : 8'h00;
	// Bit 0 covers A and B together, bits 1..7 ports C..J
	assign weak_drive_port = dr_ff;

endmodule : pfs_port_pin_function_select

`default_nettype wire

// ===== verif/pfs_monitor.sv
// Port checker for the port pin function select block
`timescale 1ns/1ps
`default_nettype none
module pfs_monitor (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [3:0]  pstrb,
	input wire logic [31:0] prdata,
	input wire logic        pslverr,
	input wire logic [2:0]  mode_pins,
	input wire logic        addr_bus_a,
	input wire logic        addr_bus_b,
	input wire logic [7:0]  dir_a,
	input wire logic [7:0]  dir_b,
	input wire logic [7:0]  port_e_pin_in,
	input wire logic        aux_reset_req,
	input wire logic        eclk_in,
	input wire logic [7:0]  pullup_a,
	input wire logic [7:0]  pullup_b,
	input wire logic [7:0]  pullup_e,
	input wire logic [7:0]  weak_drive_port
);
	// ========
	// Access decode
	logic acc;
	logic unmap;
	logic wr_drv;
	assign acc = psel && penable;
	assign unmap = (paddr[11:2] != 10'h002 && paddr[11:2] != 10'h003)
		|| (mode_pins == pfs_pkg::MODE_PERIPHERAL && paddr[11:2] == 10'h003);
	assign wr_drv = acc && pwrite && paddr[11:2] == 10'h003 && pstrb[1];
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	// ========
	// Properties
	sequence s_rd_setup;
		psel && !penable && !pwrite;
	endsequence
	sequence s_periph_hi;
		(mode_pins == pfs_pkg::MODE_PERIPHERAL && port_e_pin_in[4]) [*5];
	endsequence
	a_unmap_err: assert property (acc && unmap |-> pslverr)
		else $error("unmapped access without error");
	a_map_ok: assert property (acc && !unmap |-> !pslverr)
		else $error("mapped access flagged as error");
	a_unmap_rd0: assert property (s_rd_setup ##0 unmap |=> prdata == 32'h0000_0000)
		else $error("unmapped read returned data");
	a_rdata_hold: assert property (!(psel && !penable && !pwrite) |=> $stable(prdata))
		else $error("read data changed outside a read setup");
	a_pu_input: assert property (((pullup_a & dir_a) | (pullup_b & dir_b)) == 8'h00)
		else $error("pullup on an output pin");
	a_pu_e_pins: assert property ((pullup_e & 8'hF2) == 8'h00)
		else $error("port E pullup on a pin without one");
	a_bus_no_pu: assert property ((addr_bus_a ? pullup_a : 8'h00) == 8'h00
		&& (addr_bus_b ? pullup_b : 8'h00) == 8'h00)
		else $error("pullup active on an address bus port");
	a_drive_special: assert property (!mode_pins[2] |=> $stable(weak_drive_port))
		else $error("drive strength changed in special mode");
	a_drive_hold: assert property (!wr_drv && !$past(wr_drv) |=> $stable(weak_drive_port))
		else $error("drive strength changed without a write");
	a_aux_off: assert property ((!port_e_pin_in[7]) [*4] |-> !aux_reset_req)
		else $error("aux reset with the pin low");
	a_eclk_in: assert property (s_periph_hi |-> !eclk_in)
		else $error("bus clock input active while the pin is general I/O");
endmodule // pfs_monitor

bind pfs_port_pin_function_select pfs_monitor u_mon (
	.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pstrb, .prdata, .pslverr, .mode_pins,
	.addr_bus_a, .addr_bus_b, .dir_a, .dir_b, .port_e_pin_in, .aux_reset_req, .eclk_in,
	.pullup_a, .pullup_b, .pullup_e, .weak_drive_port
);
`default_nettype wire

// ===== verif/test_port_pin_function_select.sv
// Self-checking bench for the port pin function select block
`timescale 1ns/1ps
`default_nettype none
module test_port_pin_function_select;
	logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, er;
	logic        ab_a = 0, ab_b = 0, db_c = 0, db_d = 0, synth_test_sig = 1;
	logic        bus_eclk = 0, bus_low_byte_strobe = 1, bus_rw = 1;
	logic        pready, pslverr, aux_reset_req, eclk_in;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, rd;
	logic [3:0]  pstrb = 0;
	logic [2:0]  mode_pins = 0;
	logic [1:0]  queue_state = 2'h2;
	logic [7:0]  pe_dir = 0, pe_data = 0, pe_pin = 0, dirv = 0;
	logic [7:0]  port_e_out, port_e_oe_n, weak_drive_port;
	logic [7:0]  pu [8];
	int          failures = 0, num_checks = 0;

	pfs_port_pin_function_select dut (
		.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready,
		.pslverr, .mode_pins, .addr_bus_a(ab_a), .addr_bus_b(ab_b), .data_bus_c(db_c),
		.data_bus_d(db_d), .port_e_direction(pe_dir), .port_e_data(pe_data),
		.port_e_pin_in(pe_pin), .dir_a(dirv), .dir_b(dirv), .dir_c(dirv), .dir_d(dirv),
		.dir_f(dirv), .dir_g(dirv), .dir_h(dirv), .synth_test_sig, .queue_state, .bus_eclk,
		.bus_low_byte_strobe, .bus_rw, .port_e_out, .port_e_oe_n, .aux_reset_req, .eclk_in,
		.pullup_a(pu[0]), .pullup_b(pu[1]), .pullup_c(pu[2]), .pullup_d(pu[3]),
		.pullup_e(pu[4]), .pullup_f(pu[5]), .pullup_g(pu[6]), .pullup_h(pu[7]), .weak_drive_port
	);

	initial begin
		forever #25 pclk = ~pclk;
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			failures++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic end_of_test;
		if (failures == 0 && num_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// Setup, then access held until pready is seen high
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		input logic [3:0] s);
		int n;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		pstrb <= s;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		if (pready !== 1'b1) begin
			failures++;
			end_of_test();
		end
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	task automatic rchk(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
		apb(1'b0, a, 32'h0000_0000, 4'h0);
		chk(rd & m, e);
	endtask

	task automatic do_reset(input logic [2:0] m);
		presetn <= 1'b0;
		mode_pins <= m;
		ab_a <= 1'b0;
		ab_b <= 1'b0;
		db_c <= 1'b0;
		db_d <= 1'b0;
		pe_dir <= 8'h00;
		@(posedge pclk);
		@(posedge pclk);
		chk({port_e_out[3], port_e_oe_n[3]}, 2'h2);
		presetn <= 1'b1;
		repeat (7) @(posedge pclk);
	endtask

	initial begin
		do_reset(pfs_pkg::MODE_NORMAL_EXPN);
		rchk(12'h008, 32'h08FF_0000, 32'h0000_0000);
		chk(port_e_oe_n[4], 1'h0);
		apb(1'b1, 12'h008, 32'h002C_0000, 4'h4);
		rchk(12'h008, 32'h00FF_0000, 32'h002C_0000);
		chk(port_e_oe_n[6:2], 5'h02);
		chk(port_e_out[2], bus_rw);
		apb(1'b1, 12'h008, 32'h00D0_0000, 4'h4);
		rchk(12'h008, 32'h00FF_0000, 32'h00BC_0000);
		pe_pin <= 8'h80;
		dirv <= 8'h0F;
		repeat (4) @(posedge pclk);
		chk(aux_reset_req, 1'h1);
		chk(port_e_oe_n[4], 1'h1);
		pe_pin <= 8'h00;
		apb(1'b1, 12'h00C, 32'h0000_A5FF, 4'h3);
		rchk(12'h00C, 32'h0000_FFFF, 32'h0000_A5FF);
		ab_b <= 1'b1;
		db_c <= 1'b1;
		repeat (3) @(posedge pclk);
		chk(weak_drive_port, 8'hA5);
		chk({pu[0], pu[1], pu[2], pu[3]}, 32'hF000_00F0);
		chk({pu[4], pu[5]}, 16'h09F0);
		ab_a <= 1'b1;
		ab_b <= 1'b0;
		db_c <= 1'b0;
		db_d <= 1'b1;
		@(posedge pclk);
		chk({pu[0], pu[1], pu[2], pu[3]}, 32'h00F0_F000);
		rchk(12'h010, 32'hFFFF_FFFF, 32'h0000_0000);
		chk(er, 1'h1);
		do_reset(pfs_pkg::MODE_SPECIAL_SC);
		rchk(12'h008, 32'h00FF_0000, 32'h002C_0000);
		apb(1'b1, 12'h008, 32'h0000_0000, 4'h4);
		rchk(12'h008, 32'h00FF_0000, 32'h002C_0000);
		apb(1'b1, 12'h008, 32'h007C_0000, 4'h4);
		apb(1'b1, 12'h00C, 32'h0000_5A00, 4'h2);
		rchk(12'h008, 32'h00FF_0000, 32'h006C_0000);
		chk(port_e_oe_n[6:2], 5'h1F);
		rchk(12'h00C, 32'h0000_FF00, 32'h0000_0000);
		do_reset(pfs_pkg::MODE_PERIPHERAL);
		rchk(12'h008, 32'hFFFF_FFFF, 32'h0000_0000);
		chk(er, 1'h0);
		rchk(12'h00C, 32'hFFFF_FFFF, 32'h0000_0000);
		chk(er, 1'h1);
		pe_pin <= 8'h10;
		repeat (6) @(posedge pclk);
		chk(eclk_in, 1'h0);
		chk({port_e_oe_n[6], port_e_out[6]}, {1'b0, synth_test_sig});
		pe_pin <= 8'h00;
		repeat (3) @(posedge pclk);
		chk(eclk_in, 1'h0);
		do_reset(pfs_pkg::MODE_SPECIAL_EXPW);
		pe_dir <= 8'hFC;
		pe_data <= 8'h80;
		repeat (2) @(posedge pclk);
		chk({port_e_oe_n[7:2], port_e_out[7]}, 7'h01);
		chk(port_e_out[3:2], {bus_low_byte_strobe, bus_rw});
		do_reset(pfs_pkg::MODE_NORMAL_SC);
		rchk(12'h008, 32'h00FF_0000, 32'h0010_0000);
		chk(port_e_oe_n[4], 1'h1);
		apb(1'b1, 12'h008, 32'h0800_0000, 4'hC);
		rchk(12'h008, 32'h08FF_0000, 32'h0800_0000);
		chk(port_e_oe_n[4], 1'h0);
		do_reset(pfs_pkg::MODE_NORMAL_EXPW);
		apb(1'b1, 12'h008, 32'h000C_0000, 4'h4);
		apb(1'b1, 12'h008, 32'h0000_0000, 4'h4);
		rchk(12'h008, 32'h00FF_0000, 32'h000C_0000);
		chk({port_e_oe_n[3:2], port_e_out[3:2]}, {2'h0, bus_low_byte_strobe, bus_rw});
		end_of_test();
	end
endmodule // test_port_pin_function_select
`default_nettype wire
